// ===== include/ext_int_pkg.sv
// package: register map, field positions and bus carrier for the external interrupt block
package ext_int_pkg;

    // ****************************************
    // bus geometry
    // ****************************************
    localparam int WB_ADDR_WIDTH = 8;
    localparam int WB_DATA_WIDTH = 32;
    localparam int WB_SEL_WIDTH = 4;

    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [WB_ADDR_WIDTH-1:0] EXT_INT_A_CONTROL_OFFSET = 8'h18;
    localparam logic [WB_ADDR_WIDTH-1:0] EXT_INT_B_STATUS_CONTROL_OFFSET = 8'h1C;
    localparam logic [WB_ADDR_WIDTH-1:0] IRQ_STATUS_OFFSET = 8'h20;
    localparam logic [WB_ADDR_WIDTH-1:0] IRQ_ENABLE_OFFSET = 8'h24;

    // ****************************************
    // field positions, shared by both pin control registers except the pull-up disable bit, which only the second pin's register has
    // ****************************************
    localparam int SENSE_BIT = 0;
    localparam int MASK_BIT = 1;
    localparam int ACK_BIT = 2;
    localparam int PENDING_BIT = 3;
    localparam int PULLUP_DISABLE_BIT = 6;

    // sticky event bits in status and enable registers
    localparam int EVENT_A_BIT = 0;
    localparam int EVENT_B_BIT = 1;
    localparam int EVENT_COUNT = 2;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [EVENT_COUNT-1:0] EVENT_RESET = 2'h0;

    // ****************************************
    // timing: synchroniser depth on each pin
    // ****************************************
    localparam int SYNC_STAGES_DEFAULT = 2;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [WB_ADDR_WIDTH-1:0] adr;
        logic [WB_SEL_WIDTH-1:0] sel;
        logic [WB_DATA_WIDTH-1:0] dat;
    } wb_req_type;

    typedef struct packed {
        logic pullup_disable;
        logic mask;
        logic sense;
    } pin_cfg_type;

endpackage

// ===== src/ext_int_pin.sv
// one external interrupt pin: synchroniser, falling edge detector and request latch
`timescale 1ns/1ps
module ext_int_pin
    import ext_int_pkg::*;
#(
    parameter int SYNC_STAGES = SYNC_STAGES_DEFAULT
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_n_i,
    input wire logic sense_i,
    input wire logic ack_i,
    output logic latch_o,
    output logic set_o
);

    initial
    begin
        if (SYNC_STAGES < 2)
            $error("ext_int_pin: SYNC_STAGES must be at least 2");
    end

    logic [SYNC_STAGES-1:0] sync_q;
    logic prev_q;
    logic latch_q;
    logic pin_low;
    logic fall;

    // ****************************************
    // synchroniser; idle level is high so reset makes no edge
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sync_q <= '1;
        else
            sync_q <= {sync_q[SYNC_STAGES-2:0], pin_n_i}; // see RULE_10
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            prev_q <= 1'b1;
        else
            prev_q <= sync_q[SYNC_STAGES-1];
    end

    assign pin_low = ~sync_q[SYNC_STAGES-1];
    assign fall = prev_q & pin_low; // see RULE_10
    assign set_o = fall | (sense_i & pin_low); // see RULE_09

    // ****************************************
    // request latch; a new request wins over an acknowledge
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            latch_q <= 1'b0;
        else if (set_o)
            latch_q <= 1'b1; // see RULE_09
        else if (ack_i)
            latch_q <= 1'b0;
    end

    assign latch_o = latch_q;

    fall_single_a: assert property (@(posedge clk_i) disable iff (rst_i) fall |=> !fall) // see RULE_10
        else $error("falling edge seen for two cycles");

endmodule

// ===== src/ext_int_ctrl.sv
// external interrupt pin controller with wishbone register access
//
// Notes on behaviour
// RULE_01 - While the first pin's mask bit is 1 its requests are blocked, while 0 they pass, and reset clears it.
// RULE_02 - The first pin's sense bit picks falling edge plus low level when 1 and falling edge only when 0.
// RULE_03 - Bit 6 of the second pin's register disables that pin's pull-up when 1 and reset clears it.
// RULE_04 - Bit 3 of the second pin's register is a read-only flag showing that its request is pending.
// RULE_05 - Writing 1 to bit 2 of the second pin's register clears its latch, and the bit always reads 0.
// RULE_06 - Bit 1 of the second pin's register masks that pin's requests when 1 and reset clears it.
// RULE_07 - Bit 0 of the second pin's register picks falling edge plus low level when 1, edge only when 0.
// RULE_08 - The second pin's register sits at 0x1C, resets to zero and reads 0 in bits 7, 5 and 4.
// RULE_09 - A falling edge sets the latch, a low level holds it in level mode, and latch with clear mask requests.
// RULE_10 - Each pin is synchronised before edge detection so that one falling edge sets the latch once.
`timescale 1ns/1ps
module ext_int_ctrl
    import ext_int_pkg::*;
#(
    parameter int SYNC_STAGES = SYNC_STAGES_DEFAULT
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire wb_req_type wb_i,
    output logic [WB_DATA_WIDTH-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_int_a_n_i,
    input wire logic ext_int_b_n_i,
    output logic cpu_irq_a_o,
    output logic cpu_irq_b_o,
    output logic ext_int_b_pullup_disable_o,
    output logic irq_o
);

    initial
    begin
        if (SYNC_STAGES < 2)
            $error("ext_int_ctrl: SYNC_STAGES must be at least 2");
    end

    // ****************************************
    // state
    // ****************************************
    pin_cfg_type a_cfg_q;
    pin_cfg_type b_cfg_q;
    logic [EVENT_COUNT-1:0] status_q;
    logic [EVENT_COUNT-1:0] enable_q;
    logic ack_q;
    logic [WB_DATA_WIDTH-1:0] dat_q;
    logic [WB_DATA_WIDTH-1:0] dat_d;

    logic latch_a;
    logic latch_b;
    logic set_a;
    logic set_b;
    logic ack_a;
    logic ack_b;
    logic req;
    logic wr;
    logic wr_a;
    logic wr_b;
    logic wr_status;
    logic wr_enable;
    logic [EVENT_COUNT-1:0] event_new;

    // ****************************************
    // bus decode
    // ****************************************
    assign req = wb_i.cyc & wb_i.stb;
    // writes take effect on the edge where the master sees ack
    assign wr = req & wb_i.we & ack_q & wb_i.sel[0];
    assign wr_a = wr & (wb_i.adr == EXT_INT_A_CONTROL_OFFSET);
    assign wr_b = wr & (wb_i.adr == EXT_INT_B_STATUS_CONTROL_OFFSET); // see RULE_08
    assign wr_status = wr & (wb_i.adr == IRQ_STATUS_OFFSET);
    assign wr_enable = wr & (wb_i.adr == IRQ_ENABLE_OFFSET);

    assign ack_a = wr_a & wb_i.dat[ACK_BIT];
    assign ack_b = wr_b & wb_i.dat[ACK_BIT]; // see RULE_05

    // ****************************************
    // bus acknowledge: one cycle after the request is seen
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_q <= 1'b0;
        else
            ack_q <= req & ~ack_q;
    end

    assign wb_ack_o = ack_q;

    // ****************************************
    // read data, captured together with ack
    // ****************************************
    always_comb
    begin
        dat_d = '0;
        unique case (wb_i.adr)
            EXT_INT_A_CONTROL_OFFSET:
            begin
                dat_d[SENSE_BIT] = a_cfg_q.sense;
                dat_d[MASK_BIT] = a_cfg_q.mask;
                dat_d[PENDING_BIT] = latch_a;
            end
            EXT_INT_B_STATUS_CONTROL_OFFSET:
            begin
                dat_d[SENSE_BIT] = b_cfg_q.sense; // see RULE_07
                dat_d[MASK_BIT] = b_cfg_q.mask; // see RULE_06
                dat_d[PENDING_BIT] = latch_b; // see RULE_04
                dat_d[PULLUP_DISABLE_BIT] = b_cfg_q.pullup_disable; // see RULE_03
            end
            IRQ_STATUS_OFFSET:
            begin
                dat_d[EVENT_COUNT-1:0] = status_q;
            end
            IRQ_ENABLE_OFFSET:
            begin
                dat_d[EVENT_COUNT-1:0] = enable_q;
            end
            default:
            begin
                dat_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_q <= '0;
        else if (req & ~ack_q & ~wb_i.we)
            dat_q <= dat_d;
        else
            dat_q <= '0;
    end

    assign wb_dat_o = dat_q;

    // ****************************************
    // first pin control
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            a_cfg_q.mask <= CONTROL_RESET[MASK_BIT]; // see RULE_01
            a_cfg_q.sense <= CONTROL_RESET[SENSE_BIT]; // see RULE_02
            a_cfg_q.pullup_disable <= CONTROL_RESET[PULLUP_DISABLE_BIT];
        end
        else if (wr_a)
        begin
            a_cfg_q.mask <= wb_i.dat[MASK_BIT]; // see RULE_01
            a_cfg_q.sense <= wb_i.dat[SENSE_BIT]; // see RULE_02
            a_cfg_q.pullup_disable <= CONTROL_RESET[PULLUP_DISABLE_BIT];
        end
    end

    // ****************************************
    // second pin status and control
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            b_cfg_q.mask <= CONTROL_RESET[MASK_BIT]; // see RULE_06
            b_cfg_q.sense <= CONTROL_RESET[SENSE_BIT]; // see RULE_07
            b_cfg_q.pullup_disable <= CONTROL_RESET[PULLUP_DISABLE_BIT]; // see RULE_03
        end
        else if (wr_b)
        begin
            b_cfg_q.mask <= wb_i.dat[MASK_BIT]; // see RULE_06
            b_cfg_q.sense <= wb_i.dat[SENSE_BIT]; // see RULE_07
            b_cfg_q.pullup_disable <= wb_i.dat[PULLUP_DISABLE_BIT]; // see RULE_03
        end
    end

    assign ext_int_b_pullup_disable_o = b_cfg_q.pullup_disable; // see RULE_03

    // ****************************************
    // pin front ends
    // ****************************************
    ext_int_pin #(
        .SYNC_STAGES(SYNC_STAGES)
    ) pin_a (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_n_i(ext_int_a_n_i),
        .sense_i(a_cfg_q.sense),
        .ack_i(ack_a),
        .latch_o(latch_a),
        .set_o(set_a)
    );

    ext_int_pin #(
        .SYNC_STAGES(SYNC_STAGES)
    ) pin_b (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_n_i(ext_int_b_n_i),
        .sense_i(b_cfg_q.sense),
        .ack_i(ack_b),
        .latch_o(latch_b),
        .set_o(set_b)
    );

    // cpu requests gated by the mask bits
    assign cpu_irq_a_o = latch_a & ~a_cfg_q.mask; // see RULE_01
    assign cpu_irq_b_o = latch_b & ~b_cfg_q.mask; // see RULE_09

    // ****************************************
    // sticky event status, write one to clear; a new event wins
    // ****************************************
    assign event_new[EVENT_A_BIT] = set_a & ~latch_a;
    assign event_new[EVENT_B_BIT] = set_b & ~latch_b;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            status_q <= EVENT_RESET;
        else if (wr_status)
            status_q <= (status_q & ~wb_i.dat[EVENT_COUNT-1:0]) | event_new;
        else
            status_q <= status_q | event_new;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            enable_q <= EVENT_RESET;
        else if (wr_enable)
            enable_q <= wb_i.dat[EVENT_COUNT-1:0];
    end

    assign irq_o = |(status_q & enable_q);

    // ****************************************
    // checks
    // ****************************************
    mask_a_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_a && wb_i.dat[MASK_BIT]) |=> !cpu_irq_a_o) // see RULE_01
        else $error("first pin request passed while masked");

    level_a_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (a_cfg_q.sense && !ext_int_a_n_i && !wr_a)[*3] |=> latch_a) // see RULE_02
        else $error("first pin low level did not hold the latch");

    pullup_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_b |=> ext_int_b_pullup_disable_o == $past(wb_i.dat[PULLUP_DISABLE_BIT])) // see RULE_03
        else $error("pull-up disable did not follow the write");

    pending_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !ack_q && !wb_i.we && wb_i.adr == EXT_INT_B_STATUS_CONTROL_OFFSET)
        |=> wb_ack_o && wb_dat_o[PENDING_BIT] == $past(latch_b)) // see RULE_04
        else $error("pending flag read does not match latch");

    ack_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ack_b && !set_b) |=> !latch_b) // see RULE_05
        else $error("acknowledge did not clear the second latch");

    ack_reads_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> !wb_dat_o[ACK_BIT]) // see RULE_05
        else $error("acknowledge bit read back as one");

    mask_b_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_b && !wb_i.dat[MASK_BIT] && latch_b) |=> cpu_irq_b_o == latch_b) // see RULE_06
        else $error("second pin request blocked while unmasked");

    edge_only_b_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!b_cfg_q.sense && latch_b && ack_b && !set_b) |=> !latch_b) // see RULE_07
        else $error("edge mode latch re-set without an edge");

    unused_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !ack_q && wb_i.adr == EXT_INT_B_STATUS_CONTROL_OFFSET)
        |=> wb_dat_o[7] == 1'b0 && wb_dat_o[5:4] == 2'h0) // see RULE_08
        else $error("unimplemented bits read as one");

    fall_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(set_b) |=> latch_b && (b_cfg_q.mask || cpu_irq_b_o)) // see RULE_09
        else $error("falling edge did not raise the request");

    sync_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ext_int_a_n_i && !latch_a && !a_cfg_q.sense)[*3] ##1 !ext_int_a_n_i |-> !latch_a) // see RULE_10
        else $error("latch set before the pin was synchronised");

    irq_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (event_new[EVENT_B_BIT] && enable_q[EVENT_B_BIT] && !wr_enable) |=> irq_o)
        else $error("enabled event did not raise the interrupt");

    bus_ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("bus acknowledge held for two cycles");

    level_b_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (b_cfg_q.sense && !ext_int_b_n_i && !wr_b)[*3] |=> latch_b) // see RULE_07
        else $error("second pin low level did not hold the latch");

    status_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_status && wb_i.dat[EVENT_B_BIT] && !event_new[EVENT_B_BIT]) |=> !status_q[EVENT_B_BIT])
        else $error("status bit did not clear on write one");

    upper_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> wb_dat_o[WB_DATA_WIDTH-1:8] == '0)
        else $error("read data above the register byte is not zero");

endmodule

// ===== bench/ext_dev_model.sv
// model of the external devices that pull the two interrupt pins low
`timescale 1ns/1ps
module ext_dev_model
(
    input wire logic pull_a_i,
    input wire logic pull_b_i,
    output logic pin_a_n_o,
    output logic pin_b_n_o
);
    // a released pin rests high: pull-up on the line, or the device drives high itself
    assign pin_a_n_o = ~pull_a_i;
    assign pin_b_n_o = ~pull_b_i;
endmodule

// ===== bench/external_interrupt_pins_tb.sv
// self-checking testbench for the external interrupt pin controller
`timescale 1ns/1ps
module external_interrupt_pins_tb
    import ext_int_pkg::*;
;
    logic clk_i;
    logic rst_i;
    wb_req_type req;
    logic [WB_DATA_WIDTH-1:0] wb_dat_o;
    logic wb_ack_o;
    logic pin_a_n;
    logic pin_b_n;
    logic pull_a;
    logic pull_b;
    logic cpu_irq_a_o;
    logic cpu_irq_b_o;
    logic pullup_o;
    logic irq_o;
    int fails = 0;
    int compares = 0;

    ext_int_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ext_int_a_n_i(pin_a_n), .ext_int_b_n_i(pin_b_n), .cpu_irq_a_o(cpu_irq_a_o), .cpu_irq_b_o(cpu_irq_b_o),
        .ext_int_b_pullup_disable_o(pullup_o), .irq_o(irq_o));
    ext_dev_model i_dev (.pull_a_i(pull_a), .pull_b_i(pull_b), .pin_a_n_o(pin_a_n), .pin_b_n_o(pin_b_n));

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            $display("BAD %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask

    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk_i);
        end
        if (wb_ack_o !== 1'b1)
        begin
            $display("BAD ack expected 1 seen none");
            fails++;
            end_of_test();
        end
        rd = wb_dat_o;
        req <= '0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        xfer(1'b1, adr, dat, d);
    endtask

    task automatic rdchk(input string n, input logic [7:0] adr, input logic [31:0] e);
        logic [31:0] d;
        xfer(1'b0, adr, 32'h0, d);
        chk(n, e, d);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic hold(input int p, input logic v);
        @(posedge clk_i);
        if (p == 1)
            pull_b <= v;
        else
            pull_a <= v;
    endtask

    task automatic pulse(input int p);
        hold(p, 1'b1);
        settle(3);
        hold(p, 1'b0);
        settle(8);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset(input int n);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (n) @(posedge clk_i);
        rst_i <= 1'b0;
        settle(1);
        chk("pullup", 32'h0, 32'(pullup_o));
        chk("irq", 32'h0, 32'(irq_o));
        rdchk("reg_b", 8'h1C, 32'h0);
        rdchk("reg_a", 8'h18, 32'h0);
        rdchk("status", 8'h20, 32'h0);
        rdchk("enable", 8'h24, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_fields();
        wr(8'h1C, 32'hFF);
        rdchk("reg_b", 8'h1C, 32'h43);
        settle(1);
        chk("pullup", 32'h1, 32'(pullup_o));
        wr(8'h1C, 32'h03);
        settle(1);
        chk("pullup", 32'h0, 32'(pullup_o));
        rdchk("reg_b", 8'h1C, 32'h03);
        $display("test fields done");
    endtask

    task automatic t_pin(input int p, input logic [7:0] adr);
        wr(adr, 32'h02);
        pulse(p);
        rdchk("masked", adr, 32'h0A);
        chk("cpu_irq", 32'h0, 32'(p == 1 ? cpu_irq_b_o : cpu_irq_a_o));
        wr(adr, 32'h00);
        settle(1);
        chk("cpu_irq", 32'h1, 32'(p == 1 ? cpu_irq_b_o : cpu_irq_a_o));
        wr(adr, 32'h04);
        settle(4);
        rdchk("acked", adr, 32'h00);
        chk("cpu_irq", 32'h0, 32'(p == 1 ? cpu_irq_b_o : cpu_irq_a_o));
        wr(adr, 32'h01);
        hold(p, 1'b1);
        settle(8);
        wr(adr, 32'h05);
        rdchk("level", adr, 32'h09);
        hold(p, 1'b0);
        settle(6);
        wr(adr, 32'h05);
        rdchk("released", adr, 32'h01);
        wr(adr, 32'h00);
        $display("test pin %0d done", p);
    endtask

    task automatic t_events();
        rdchk("status", 8'h20, 32'h03);
        wr(8'h20, 32'h03);
        rdchk("status", 8'h20, 32'h0);
        wr(8'h24, 32'h02);
        pulse(1);
        chk("irq", 32'h1, 32'(irq_o));
        rdchk("status", 8'h20, 32'h02);
        wr(8'h24, 32'h00);
        settle(1);
        chk("irq", 32'h0, 32'(irq_o));
        wr(8'h24, 32'h02);
        wr(8'h20, 32'h02);
        settle(1);
        chk("irq", 32'h0, 32'(irq_o));
        wr(8'h1C, 32'h04);
        pulse(0);
        rdchk("status", 8'h20, 32'h01);
        wr(8'h30, 32'hFF);
        rdchk("unmapped", 8'h30, 32'h0);
        rdchk("reg_b", 8'h1C, 32'h0);
        $display("test events done");
    endtask

    initial
    begin
        rst_i = 1'b1;
        req = '0;
        pull_a = 1'b0;
        pull_b = 1'b0;
        t_reset(16);
        t_fields();
        t_pin(1, 8'h1C);
        t_pin(0, 8'h18);
        t_events();
        wr(8'h1C, 32'h43);
        t_reset(2);
        end_of_test();
    end
endmodule
